/* rtl/smde_top.v */
// Servo control front end: mode select, servo enable gating and direction.
//
// Contract
// (RULE1) Mode code 0 regulates speed from the analog speed command.
// (RULE2) Mode code 1 controls position from a pulse train count and rate.
// (RULE3) Mode code 2 controls torque from the analog torque command.
// (RULE4) Mode code 3 runs one of three preset speeds, analog command ignored.
// (RULE5) Further codes switch between combinations of the basic methods.
// (RULE6) Enable input low energizes the motor; high de-energizes it.
// (RULE7) Controller enables first, then starts or stops; never by enable.
// (RULE8) Enable source field picks the physical input; default input 1.
// (RULE9) Source code 9 forces servo enable asserted regardless of pin.
// (RULE10) Forced enable runs the drive as soon as power comes on.
// (RULE11) Forced enable disables alarm reset; only power cycle clears alarms.
// (RULE12) Parameter changes act only after the next power-up.
// (RULE13) Direction 0 makes forward counterclockwise; 1 makes it clockwise.
// (RULE14) Direction flips only motor rotation, never encoder or monitor outputs.
// (RULE15) Asynchronous enable and select inputs are synchronised before use.
// (RULE16) Mode, source and direction latch once after power-on reset.
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`include "smde_consts.vh"
`default_nettype none
module smde_top #(
  parameter NUM_IN = 8,
  parameter [15:0] FUNC_RST = `SMDE_FUNC_RST,
  parameter [15:0] INPUT_RST = `SMDE_INPUT_RST
) (
  // Clock and power-on reset
  input wire ref_clk,
  input wire rst,
  // Avalon-MM slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Nonvolatile parameter store, loaded at power-up and saved from outside
  input wire [15:0] nv_func_init,
  input wire [15:0] nv_input_init,
  output reg [15:0] nv_func_store,
  output reg [15:0] nv_input_store,
  // Connector inputs, active low, asynchronous
  input wire [NUM_IN-1:0] io_connector,
  input wire speed_select_a,
  input wire speed_select_b,
  input wire speed_select_c,
  input wire alarm_reset_n,
  // Internal logic on the same clock
  input wire alarm_event,
  input wire cmd_forward,
  input wire cmd_run,
  input wire encoder_a_in,
  input wire monitor_polarity_in,
  // Drive outputs
  output reg motor_energize,
  output reg motor_turn,
  output reg motor_cw,
  output reg speed_loop_en,
  output reg pos_loop_en,
  output reg torque_loop_en,
  output reg preset_speed_en,
  output reg [1:0] preset_index,
  output reg analog_cmd_used,
  output reg alarm_active,
  output reg encoder_divided_out_a,
  output reg monitor_polarity_out
);
  localparam [2:0] ST_LOAD = 3'b001;
  localparam [2:0] ST_OFF = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [3:0] mode_q;
  reg [3:0] src_q;
  reg dir_q;
  reg load_done_q;
  reg alarm_q;
  reg alarm_d;
  wire enable_n;
  reg [1:0] preset_d;
  reg [31:0] rdata_d;
  wire [NUM_IN-1:0] in_sync;
  wire [3:0] sel_sync;
  wire forced;
  wire bus_req;
  wire bus_take;
  wire speed_en;
  wire pos_en;
  wire torque_en;
  wire preset_en;

  // Picks the level of a connector input from a one-based source code.
  // An out-of-range code reads as inactive, so the motor stays off.
  function pick_pin;
    input [3:0] src;
    input [NUM_IN-1:0] pins;
    integer i;
    begin
      pick_pin = 1'b1;
      for (i = 0; i < NUM_IN; i = i + 1)
      begin
        if (src == i[3:0] + `SMDE_SRC_FIRST)
        begin
          pick_pin = pins[i];
        end
      end
    end
  endfunction

  // Byte-lane merge of a write into a 16-bit staged parameter.
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wdata;
    input [3:0] be;
    begin
      merge16 = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
    end
  endfunction

  // (RULE15) Connector input synchronisers.
  smde_sync3 #(
    .W(NUM_IN),
    .RST_VAL({NUM_IN{1'b1}})
  ) u_sync_in (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(io_connector),
    .sync_out(in_sync)
  );

  // (RULE15) Select and alarm reset synchronisers.
  smde_sync3 #(
    .W(4),
    .RST_VAL(4'hF)
  ) u_sync_sel (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({alarm_reset_n, speed_select_c, speed_select_b, speed_select_a}),
    .sync_out(sel_sync)
  );

  // The first select input doubles as the switch in the switched modes.
  smde_mode_dec u_mode_dec (
    .mode(mode_q),
    .switch_n(sel_sync[0]),
    .speed_en(speed_en),
    .pos_en(pos_en),
    .torque_en(torque_en),
    .preset_en(preset_en)
  );

  // (RULE9) Source code 9 forces enable.
  assign forced = (src_q == `SMDE_SRC_FORCED);

  // (RULE8) Select the enable source pin.
  assign enable_n = forced ? 1'b0 : pick_pin(src_q, in_sync);

  // The bus answers one cycle after a request is seen; the write lands on
  // the edge at which waitrequest is sampled low.
  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~avs_waitrequest;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read && avs_waitrequest)
      begin
        avs_readdata <= rdata_d;
      end
    end
  end

  always @*
  begin
    rdata_d = 32'h00000000;
    case (avs_address)
      `SMDE_OFS_FUNC: rdata_d[15:0] = nv_func_store;
      `SMDE_OFS_INPUT: rdata_d[15:0] = nv_input_store;
      `SMDE_OFS_ACTIVE:
      begin
        rdata_d[`SMDE_MODE_MSB:`SMDE_MODE_LSB] = mode_q;
        rdata_d[`SMDE_DIR_BIT] = dir_q;
        rdata_d[11:8] = src_q;
      end
      `SMDE_OFS_STATUS:
      begin
        rdata_d[2:0] = state_q;
        rdata_d[3] = alarm_q;
        rdata_d[4] = forced;
        rdata_d[5] = ~enable_n;
        rdata_d[9:8] = preset_index;
        rdata_d[12] = speed_loop_en;
        rdata_d[13] = pos_loop_en;
        rdata_d[14] = torque_loop_en;
        rdata_d[15] = preset_speed_en;
      end
      default: rdata_d = 32'h00000000;
    endcase
  end

  // Staged parameters: software edits these, the outside store saves them.
  // (RULE16) Active settings latch once, with the store load.
  // (RULE12) Later writes wait for power-up.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      nv_func_store <= FUNC_RST;
      nv_input_store <= INPUT_RST;
      load_done_q <= 1'b0;
      mode_q <= FUNC_RST[`SMDE_MODE_MSB:`SMDE_MODE_LSB];
      dir_q <= FUNC_RST[`SMDE_DIR_BIT];
      src_q <= INPUT_RST[`SMDE_SRC_MSB:`SMDE_SRC_LSB];
    end
    else if (!load_done_q)
    begin
      nv_func_store <= nv_func_init;
      nv_input_store <= nv_input_init;
      load_done_q <= 1'b1;
      mode_q <= nv_func_init[`SMDE_MODE_MSB:`SMDE_MODE_LSB];
      dir_q <= nv_func_init[`SMDE_DIR_BIT];
      src_q <= nv_input_init[`SMDE_SRC_MSB:`SMDE_SRC_LSB];
    end
    else if (bus_take && avs_write)
    begin
      if (avs_address == `SMDE_OFS_FUNC)
      begin
        nv_func_store <= merge16(nv_func_store, avs_writedata, avs_byteenable);
      end
      if (avs_address == `SMDE_OFS_INPUT)
      begin
        nv_input_store <= merge16(nv_input_store, avs_writedata, avs_byteenable);
      end
    end
  end

  // Alarm is sticky; a new event in the clear cycle wins.
  always @*
  begin
    alarm_d = alarm_q;
    // (RULE11) Alarm reset ignored when forced.
    if (!sel_sync[3] && !forced && state_q != ST_LOAD)
    begin
      alarm_d = 1'b0;
    end
    if (alarm_event)
    begin
      alarm_d = 1'b1;
    end
  end

  // Servo state machine.
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_LOAD: state_d = ST_OFF;
      ST_OFF:
      begin
        // (RULE6) Low enable turns servo on.
        // (RULE10) Forced enable runs at once.
        if (!enable_n && !alarm_d)
        begin
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        // (RULE6) High enable turns servo off.
        if (enable_n || alarm_d)
        begin
          state_d = ST_OFF;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= ST_LOAD;
      alarm_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      alarm_q <= alarm_d;
    end
  end

  // (RULE4) Preset picked by select inputs, first has priority.
  always @*
  begin
    preset_d = `SMDE_PRESET_NONE;
    if (!sel_sync[0] && mode_q == `SMDE_MODE_PRESET)
    begin
      preset_d = `SMDE_PRESET_1;
    end
    else if (!sel_sync[1])
    begin
      preset_d = `SMDE_PRESET_2;
    end
    else if (!sel_sync[2])
    begin
      preset_d = `SMDE_PRESET_3;
    end
  end

  // Registered drive outputs.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      motor_energize <= 1'b0;
      motor_turn <= 1'b0;
      motor_cw <= 1'b0;
      speed_loop_en <= 1'b0;
      pos_loop_en <= 1'b0;
      torque_loop_en <= 1'b0;
      preset_speed_en <= 1'b0;
      preset_index <= `SMDE_PRESET_NONE;
      analog_cmd_used <= 1'b0;
      alarm_active <= 1'b0;
      encoder_divided_out_a <= 1'b0;
      monitor_polarity_out <= 1'b0;
    end
    else
    begin
      // (RULE6) Energize only in run state.
      motor_energize <= (state_d == ST_RUN);
      // (RULE7) Start and stop act only while energized.
      motor_turn <= (state_d == ST_RUN) && cmd_run;
      // (RULE13) Direction bit sets rotation.
      motor_cw <= cmd_forward ? dir_q : ~dir_q;
      // (RULE1) Speed loop enable.
      speed_loop_en <= (state_d == ST_RUN) && speed_en;
      // (RULE2) Position loop enable.
      pos_loop_en <= (state_d == ST_RUN) && pos_en;
      // (RULE3) Torque loop enable.
      torque_loop_en <= (state_d == ST_RUN) && torque_en;
      // (RULE4) Preset speed enable.
      preset_speed_en <= (state_d == ST_RUN) && preset_en;
      preset_index <= preset_en ? preset_d : `SMDE_PRESET_NONE;
      // (RULE4) Analog command unused for presets.
      analog_cmd_used <= (speed_en | torque_en) & ~preset_en;
      alarm_active <= alarm_d;
      // (RULE14) Encoder and monitor pass unchanged.
      encoder_divided_out_a <= encoder_a_in;
      monitor_polarity_out <= monitor_polarity_in;
    end
  end
endmodule // smde_top
`default_nettype wire

/* rtl/smde_consts.vh */
// Constants shared by the servo mode, enable and direction front end.
`ifndef SMDE_CONSTS_VH
`define SMDE_CONSTS_VH

// Register byte offsets on the Avalon-MM slave.
`define SMDE_OFS_FUNC 5'h00
`define SMDE_OFS_INPUT 5'h04
`define SMDE_OFS_ACTIVE 5'h08
`define SMDE_OFS_STATUS 5'h0C

// Field positions inside the function and input-assignment parameters.
`define SMDE_DIR_BIT 0
`define SMDE_MODE_MSB 7
`define SMDE_MODE_LSB 4
`define SMDE_SRC_MSB 7
`define SMDE_SRC_LSB 4

// Reset values of the staged parameters before the store is loaded.
`define SMDE_FUNC_RST 16'h0000
`define SMDE_INPUT_RST 16'h0010

// Control-mode codes.
`define SMDE_MODE_SPEED 4'h0
`define SMDE_MODE_POS 4'h1
`define SMDE_MODE_TORQUE 4'h2
`define SMDE_MODE_PRESET 4'h3
`define SMDE_MODE_SW_PRE_SPD 4'h4
`define SMDE_MODE_SW_PRE_POS 4'h5
`define SMDE_MODE_SW_PRE_TRQ 4'h6
`define SMDE_MODE_SW_POS_SPD 4'h7
`define SMDE_MODE_SW_POS_TRQ 4'h8
`define SMDE_MODE_SW_TRQ_SPD 4'h9

// Enable source codes: 1..8 pick an input pin, 9 forces enable valid.
`define SMDE_SRC_FIRST 4'h1
`define SMDE_SRC_LAST 4'h8
`define SMDE_SRC_FORCED 4'h9

// Preset speed indices, zero meaning no preset selected.
`define SMDE_PRESET_NONE 2'h0
`define SMDE_PRESET_1 2'h1
`define SMDE_PRESET_2 2'h2
`define SMDE_PRESET_3 2'h3

`endif

/* rtl/smde_sync3.v */
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module smde_sync3 #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Data
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  wire [W-1:0] agree;

  assign agree = ~(s2_q ^ s3_q);

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_out <= (s3_q & agree) | (sync_out & ~agree);
    end
  end
endmodule // smde_sync3
`default_nettype wire

/* rtl/smde_mode_dec.v */
// Decoder from the latched control-mode code to the loop enables.
`include "smde_consts.vh"
`default_nettype none
module smde_mode_dec (
  // Mode code and switch input (low selects the second method)
  input wire [3:0] mode,
  input wire switch_n,
  // Loop enables
  output reg speed_en,
  output reg pos_en,
  output reg torque_en,
  output reg preset_en
);
  always @*
  begin
    speed_en = 1'b0;
    pos_en = 1'b0;
    torque_en = 1'b0;
    preset_en = 1'b0;
    case (mode)
      // (RULE1) Analog speed mode.
      `SMDE_MODE_SPEED: speed_en = 1'b1;
      // (RULE2) Pulse-train position mode.
      `SMDE_MODE_POS: pos_en = 1'b1;
      // (RULE3) Analog torque mode.
      `SMDE_MODE_TORQUE: torque_en = 1'b1;
      // (RULE4) Internal preset speeds.
      `SMDE_MODE_PRESET: preset_en = 1'b1;
      // (RULE5) Switched combinations.
      `SMDE_MODE_SW_PRE_SPD:
      begin
        preset_en = switch_n;
        speed_en = ~switch_n;
      end
      `SMDE_MODE_SW_PRE_POS:
      begin
        preset_en = switch_n;
        pos_en = ~switch_n;
      end
      `SMDE_MODE_SW_PRE_TRQ:
      begin
        preset_en = switch_n;
        torque_en = ~switch_n;
      end
      `SMDE_MODE_SW_POS_SPD:
      begin
        pos_en = switch_n;
        speed_en = ~switch_n;
      end
      `SMDE_MODE_SW_POS_TRQ:
      begin
        pos_en = switch_n;
        torque_en = ~switch_n;
      end
      `SMDE_MODE_SW_TRQ_SPD:
      begin
        torque_en = switch_n;
        speed_en = ~switch_n;
      end
      default:
      begin
        speed_en = 1'b0;
      end
    endcase
  end
endmodule // smde_mode_dec
`default_nettype wire

/* verification/smde_top_monitor.sv */
// Checker for the servo front end drive outputs.
`default_nettype none
module smde_top_monitor #(
  parameter NUM_IN = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched inputs
  input wire logic [NUM_IN-1:0] io_connector,
  input wire logic cmd_forward,
  input wire logic encoder_a_in,
  input wire logic monitor_polarity_in,
  // Watched outputs
  input wire logic motor_energize,
  input wire logic motor_turn,
  input wire logic motor_cw,
  input wire logic speed_loop_en,
  input wire logic pos_loop_en,
  input wire logic torque_loop_en,
  input wire logic preset_speed_en,
  input wire logic analog_cmd_used,
  input wire logic alarm_active,
  input wire logic encoder_divided_out_a,
  input wire logic monitor_polarity_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Edges since reset release; the load cycle must pass before outputs are judged.
  logic [1:0] up_q;
  always @(posedge ref_clk)
  begin
    if (rst)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_loop_onehot;
    $onehot0({speed_loop_en, pos_loop_en, torque_loop_en, preset_speed_en});
  endproperty
  a_loop_onehot: assert property (p_loop_onehot) else $error("two loops enabled");
  property p_loop_on;
    (speed_loop_en || pos_loop_en || torque_loop_en || preset_speed_en) |-> motor_energize;
  endproperty
  a_loop_on: assert property (p_loop_on) else $error("loop enabled while servo off");
  property p_turn_on;
    motor_turn |-> motor_energize;
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("motor turns while servo off");
  property p_preset;
    preset_speed_en |-> !analog_cmd_used && !speed_loop_en;
  endproperty
  a_preset: assert property (p_preset) else $error("preset uses analog command");
  property p_cw;
    up_q == 2'h3 |-> (motor_cw ^ $past(motor_cw)) == ($past(cmd_forward) ^ $past(cmd_forward, 2));
  endproperty
  a_cw: assert property (p_cw) else $error("rotation not following command");
  property p_pass;
    up_q != 2'h0 |-> encoder_divided_out_a == $past(encoder_a_in)
      && monitor_polarity_out == $past(monitor_polarity_in);
  endproperty
  a_pass: assert property (p_pass) else $error("encoder or monitor output altered");
  property p_sync;
    $fell(io_connector[0]) |-> !$rose(motor_energize) [*5];
  endproperty
  a_sync: assert property (p_sync) else $error("enable used before synchroniser");
  property p_alarm;
    $rose(alarm_active) |-> ##[0:2] !motor_energize;
  endproperty
  a_alarm: assert property (p_alarm) else $error("servo stays on under alarm");
endmodule // smde_top_monitor
bind smde_top smde_top_monitor #(.NUM_IN(NUM_IN)) u_mon (.*);
`default_nettype wire

/* verification/smde_ctrl_model.sv */
// Motion controller model driving servo enable and run request.
`default_nettype none
module smde_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Bench requests
  input wire logic req_on,
  input wire logic req_run,
  // Drive side
  output logic [7:0] io_connector,
  output logic cmd_run
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_n_q = 1'b1;
  logic run_q = 1'b0;
  always @(posedge ref_clk)
  begin
    run_q <= req_run & req_on & ~en_n_q;
    en_n_q <= ~(req_on | run_q);
  end
  // Unused inputs sit at their pull-up level, which is inactive.
  assign io_connector = {7'h7F, en_n_q};
  assign cmd_run = run_q;
endmodule // smde_ctrl_model
`default_nettype wire

/* verification/smde_top_tb.sv */
// Self-checking testbench for the servo front end.
`default_nettype none
module smde_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hF;
  logic [15:0] nv_func_init = 16'h0, nv_input_init = 16'h10, nv_func_store, nv_input_store;
  logic [7:0] io_connector;
  logic speed_select_a = 1'b1, speed_select_b = 1'b1, speed_select_c = 1'b1;
  logic alarm_reset_n = 1'b1, alarm_event = 1'b0, cmd_forward = 1'b1, cmd_run;
  logic encoder_a_in = 1'b0, monitor_polarity_in = 1'b0, req_on = 1'b0, req_run = 1'b0;
  logic motor_energize, motor_turn, motor_cw, speed_loop_en, pos_loop_en, torque_loop_en;
  logic preset_speed_en, analog_cmd_used, alarm_active, encoder_divided_out_a;
  logic monitor_polarity_out;
  logic [1:0] preset_index;
  int errors = 0, compares = 0, cycles = 0;
  // Expected {speed, pos, torque, preset} enables per mode code, one nibble each.
  localparam logic [43:0] loops_hi = 44'h02441111248;
  localparam logic [39:0] loops_lo = 40'h8282480000;
  wire [3:0] loops = {speed_loop_en, pos_loop_en, torque_loop_en, preset_speed_en};
  always #2 ref_clk = ~ref_clk;
  smde_top dut (.*);
  smde_ctrl_model u_ctrl (.*);
  task report_and_stop;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      errors++;
      report_and_stop;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task power_up(input logic [15:0] f, input logic [15:0] i);
    nv_func_init <= f;
    nv_input_init <= i;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge ref_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wait_en(input logic v);
    for (int n = 0; n < 20 && motor_energize !== v; n++)
      @(posedge ref_clk);
    chk("energize", {31'h0, v}, {31'h0, motor_energize});
  endtask
  task t_regs;
    power_up(16'h0031, 16'h0010);
    bus(1'b0, 5'h08, 32'h0);
    chk("active", 32'h131, rd);
    bus(1'b1, 5'h00, 32'hABCD0020);
    bus(1'b1, 5'h04, 32'h20);
    bus(1'b1, 5'h08, 32'hFFFF);
    bus(1'b0, 5'h00, 32'h0);
    chk("func", 32'h20, rd);
    bus(1'b0, 5'h08, 32'h0);
    chk("active_kept", 32'h131, rd);
    bus(1'b0, 5'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("store", 32'h20, {16'h0, nv_func_store});
    bus(1'b0, 5'h04, 32'h0);
    chk("input", 32'h20, rd);
    chk("input_store", 32'h20, {16'h0, nv_input_store});
    power_up(nv_func_store, nv_input_store);
    bus(1'b0, 5'h08, 32'h0);
    chk("active_new", 32'h220, rd);
  endtask
  task t_modes;
    for (int m = 0; m < 11; m++)
    begin
      speed_select_b <= (m < 3);
      encoder_a_in <= m[0];
      monitor_polarity_in <= ~m[0];
      power_up({8'h00, m[3:0], 3'h0, m[0]}, 16'h0010);
      req_on <= 1'b1;
      req_run <= 1'b1;
      wait_en(1'b1);
      repeat (3) @(posedge ref_clk);
      chk("loops", loops_hi[4*m +: 4], loops); // 5
      chk("cw", m[0], motor_cw);
      chk("turn", 1, motor_turn);
      chk("enc", m[0], encoder_divided_out_a);
      chk("mon", {31'h0, ~m[0]}, monitor_polarity_out);
      cmd_forward <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("cw_rev", {31'h0, ~m[0]}, motor_cw);
      cmd_forward <= 1'b1;
      if (m == 3)
        chk("preset", 3'h4, {preset_index, analog_cmd_used});
      if (m >= 4 && m <= 9)
      begin
        speed_select_a <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("switch", loops_lo[4*m +: 4], loops);
        speed_select_a <= 1'b1;
      end
      req_on <= 1'b0;
      req_run <= 1'b0;
      wait_en(1'b0);
    end
  endtask
  task t_forced;
    power_up(16'h0000, 16'h0090);
    wait_en(1'b1);
    bus(1'b0, 5'h0C, 32'h0);
    chk("status", 32'h1034, rd);
    alarm_event <= 1'b1;
    @(posedge ref_clk);
    alarm_event <= 1'b0;
    alarm_reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("alarm_kept", 2'h2, {alarm_active, motor_energize});
    power_up(16'h0000, 16'h0010);
    chk("alarm_cycled", 0, alarm_active);
    alarm_event <= 1'b1;
    @(posedge ref_clk);
    alarm_event <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("alarm_clr", 0, alarm_active);
    alarm_reset_n <= 1'b1;
    power_up(16'h0000, 16'h0020);
    req_on <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("other_pin", 0, motor_energize);
    req_on <= 1'b0;
  endtask
  initial
  begin
    @(posedge ref_clk);
    t_regs;
    t_modes;
    t_forced;
    report_and_stop;
  end
endmodule // smde_top_tb
`default_nettype wire
